// ===== bench/pcc_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// card engine model: accepts and finishes after random delays
module pcc_card_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic op_valid,
    input wire logic match, // compare result to report
    output logic op_ready,
    output logic op_done,
    output logic op_ok,
    output logic op_match
);
    int cnt; // cycles left until done
    logic run; // an operation is in progress
    // result lines carry noise outside done so stale values never help
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_ready <= 1'b0;
            op_done <= 1'b0;
            run <= 1'b0;
            cnt <= 0;
        end else begin
            op_ready <= op_valid && !op_ready && 1'($urandom);
            if (op_valid && op_ready) begin
                run <= 1'b1;
                cnt <= int'($urandom % 8);
                op_done <= 1'b0;
                op_ok <= 1'($urandom);
                op_match <= 1'($urandom);
            end else if (run && cnt == 0) begin
                run <= 1'b0;
                op_done <= 1'b1;
                op_ok <= 1'b1;
                op_match <= match;
            end else begin
                // each result line gets one value per edge
                cnt <= run ? cnt - 1 : cnt;
                op_done <= 1'b0;
                op_ok <= 1'($urandom);
                op_match <= 1'($urandom);
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench: apb master, event pulses, card model
module tb_top;
    import pcc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, slv, drive_reset = 0, match = 1;
    logic op_valid, op_ready, op_done, op_ok, op_match, tripped;
    pcc_card_s card = '0;
    pcc_op_s op, got;
    int errors = 0, cmp_count = 0, b;
    always #12.5 pclk = ~pclk;
    pcc_copy_ctrl #(.FLASH_CYC(4)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_up_evt(1'b0),
        .drive_reset(drive_reset), .menu0_chg(1'b0), .card(card),
        .drive_mode(2'b00), .op_valid(op_valid), .op_ready(op_ready),
        .op(op), .op_done(op_done), .op_ok(op_ok), .op_match(op_match),
        .eeprom_save(), .unit_leds(), .tripped(tripped));
    pcc_card_model MDL (.pclk(pclk), .presetn(presetn),
        .op_valid(op_valid), .match(match), .op_ready(op_ready),
        .op_done(op_done), .op_ok(op_ok), .op_match(op_match));
    // remember the operation the engine took
    always @(posedge pclk) if (op_valid && op_ready) got <= op;
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one apb transfer; data and error taken at the pready edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // drive reset pulse, then poll busy with a bounded count
    task run_op();
        @(posedge pclk);
        drive_reset <= 1'b1;
        @(posedge pclk);
        drive_reset <= 1'b0;
        for (int i = 0; i < 60; i++) begin
            apb(0, PCC_OFF_STAT, 0);
            if (rd[PCC_B_BUSY] === 1'b0) break;
        end
    endtask
    task final_report();
        if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        final_report();
    end
    initial begin
        void'($urandom(32'h9b197942));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, PCC_OFF_STAT, 0);
        chk(rd, 32'h0);
        apb(0, 8'h10, 0);
        chk({31'h0, slv}, 32'h1);
        // random block load from a card of other voltage rating
        b = int'($urandom % 999) + 1;
        card.present <= 1'b1;
        card.volt_diff <= 1'b1;
        apb(1, PCC_OFF_CMD, 6000 + b);
        run_op();
        chk({got.op, got.block}, {PCC_OP_LOAD, 10'(b)});
        chk({31'h0, got.skip_ra}, 32'h1);
        chk(rd[PCC_T_RATING], 1);
        apb(1, PCC_OFF_TCLR, 32'h3F);
        card.volt_diff <= 1'b0;
        // selector to card plus reset writes block 1, then idles
        apb(1, PCC_OFF_SEL, 2);
        run_op();
        chk({got.op, got.block}, {PCC_OP_WRITE, PCC_BLOCK1});
        apb(0, PCC_OFF_SEL, 0);
        chk(rd, 32'h0);
        // compare mismatch trips
        match <= 1'b0;
        apb(1, PCC_OFF_CMD, 8003);
        run_op();
        chk(rd[PCC_T_CMP], 1);
        chk({31'h0, tripped}, 32'h1);
        apb(1, PCC_OFF_TCLR, 32'h3F);
        // read-only flag turns an erase into a protect trip
        apb(1, PCC_OFF_CMD, 9888);
        run_op();
        apb(1, PCC_OFF_CMD, 7002);
        run_op();
        chk(rd[PCC_T_PROT], 1);
        final_report();
    end
endmodule
`default_nettype wire

// ===== pkg/pcc_pkg.sv
// ============================================================
// shared constants and types of the parameter card copy block
package pcc_pkg;
    // apb register byte offsets
    localparam logic [7:0] PCC_OFF_CMD = 8'h00; // command entry
    localparam logic [7:0] PCC_OFF_SEL = 8'h04; // copy mode selector
    localparam logic [7:0] PCC_OFF_STAT = 8'h08; // status, read only
    localparam logic [7:0] PCC_OFF_TCLR = 8'h0C; // trip clear, w1c
    // command entry width and special codes
    localparam int PCC_CMD_W = 14;
    localparam logic [13:0] PCC_CODE_SAVE = 14'h03E9; // 1001
    localparam logic [13:0] PCC_CODE_BOOT = 14'h07D1; // 2001
    localparam logic [13:0] PCC_CODE_SUP_CLR = 14'h2553; // 9555
    localparam logic [13:0] PCC_CODE_SUP_SET = 14'h25C2; // 9666
    localparam logic [13:0] PCC_CODE_RO_CLR = 14'h2631; // 9777
    localparam logic [13:0] PCC_CODE_RO_SET = 14'h26A0; // 9888
    localparam logic [13:0] PCC_THOUSAND = 14'h03E8;
    localparam logic [9:0] PCC_BLOCK1 = 10'h001;
    localparam int PCC_SLOTS = 1; // option slots
    localparam int PCC_LEDS = 5; // unit indicator leds
    // status bit positions
    localparam int PCC_TRIP_N = 6;
    localparam int PCC_T_MODULE = 0;
    localparam int PCC_T_RATING = 1;
    localparam int PCC_T_MODE = 2;
    localparam int PCC_T_CMP = 3;
    localparam int PCC_T_PROT = 4;
    localparam int PCC_T_CARD = 5;
    localparam int PCC_B_BUSY = 8;
    localparam int PCC_B_SUP = 9;
    localparam int PCC_B_RO = 10;
    // led flash half period
    localparam int PCC_CLK_HZ = 40_000_000;
    localparam int PCC_FLASH_MS = 250;
    localparam int PCC_FLASH_CYC = PCC_CLK_HZ / 1000 * PCC_FLASH_MS;
    typedef enum logic [2:0] {
        PCC_SEL_IDLE = 3'b000, PCC_SEL_FROM = 3'b001,
        PCC_SEL_TO = 3'b010, PCC_SEL_BACKUP = 3'b011,
        PCC_SEL_BOOT = 3'b100
    } pcc_sel_e;
    typedef enum logic [1:0] {
        PCC_OP_WRITE = 2'b00, PCC_OP_LOAD = 2'b01,
        PCC_OP_ERASE = 2'b10, PCC_OP_CMP = 2'b11
    } pcc_op_e;
    typedef enum logic [3:0] {
        PCC_K_NONE = 4'h0, PCC_K_SAVE = 4'h1, PCC_K_BOOT = 4'h2,
        PCC_K_WRITE = 4'h3, PCC_K_LOAD = 4'h4, PCC_K_ERASE = 4'h5,
        PCC_K_CMP = 4'h6, PCC_K_SUP_SET = 4'h7, PCC_K_SUP_CLR = 4'h8,
        PCC_K_RO_SET = 4'h9, PCC_K_RO_CLR = 4'hA, PCC_K_BAD = 4'hB
    } pcc_kind_e;
    typedef enum logic [1:0] {
        PCC_ST_IDLE = 2'b00, PCC_ST_ISSUE = 2'b01, PCC_ST_WAIT = 2'b10
    } pcc_st_e;
    // one card operation handed to the card transfer engine
    typedef struct packed {
        pcc_op_e op;
        logic [9:0] block;
        logic bootable;
        logic excl_nocopy; // leave out no-copy parameters
        logic excl_sel; // leave the selector out of the card image
        logic single; // one changed menu 0 parameter only
        logic skip_ra; // keep rating dependent params at default
        logic [PCC_SLOTS-1:0] keep_default; // slot menus left default
    } pcc_op_s;
    // card header as seen by the card engine
    typedef struct packed {
        logic present;
        logic block1_ok; // block 1 exists with type 1 to 4
        logic sel_boot; // selector stored on card is power_up_load
        logic [1:0] mode;
        logic volt_diff;
        logic curr_diff;
        logic [PCC_SLOTS-1:0] slot_diff;
    } pcc_card_s;
endpackage

// ===== verilog/pcc_cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// splits a decimal command code into action and block number
module pcc_cmd_decode
    import pcc_pkg::*;
(
    input wire logic [PCC_CMD_W-1:0] code,
    output pcc_kind_e kind,
    output logic [9:0] block
);
    logic [3:0] thou; // leading decimal digit
    assign thou = 4'(code / PCC_THOUSAND);
    assign block = 10'(code % PCC_THOUSAND);
    // special codes first, then by leading digit
    always_comb begin
        case (code)
            14'h0000: kind = PCC_K_NONE;
            PCC_CODE_SAVE: kind = PCC_K_SAVE;
            PCC_CODE_BOOT: kind = PCC_K_BOOT;
            PCC_CODE_SUP_SET: kind = PCC_K_SUP_SET;
            PCC_CODE_SUP_CLR: kind = PCC_K_SUP_CLR;
            PCC_CODE_RO_SET: kind = PCC_K_RO_SET;
            PCC_CODE_RO_CLR: kind = PCC_K_RO_CLR;
            default: begin
                case (thou)
                    4'h4: kind = PCC_K_WRITE;
                    4'h6: kind = PCC_K_LOAD;
                    4'h7: kind = PCC_K_ERASE;
                    4'h8: kind = PCC_K_CMP;
                    default: kind = PCC_K_BAD;
                endcase
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== verilog/pcc_copy_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Functional notes
// R1: selector copy_to_card plus reset writes block 1
// R2: writing an existing block overwrites it silently
// R3: load fills working memory and eeprom
// R4: differing slot keeps defaults, module trip
// R5: rating difference raises rating trip
// R6: voltage difference skips rating dependent parameters
// R7: current-only difference still loads them
// R8: copy_from_card plus reset loads, saves, idles
// R9: backup: full write, then single menu 0 changes
// R10: advanced changes reach card on save code
// R11: card removed in backup returns selector idle
// R12: backup power-up writes full set, leds flash
// R13: backup selector goes to eeprom, not card
// R14: power_up_load boots block 1 when conditions hold
// R15: drive mode mismatch trips, nothing transferred
// R16: boot selector written to card, never loaded
// R17: code 2001 writes bootable block 1 once
// R18: compare: match clears entry, else compare trip
// R19: 7yyy erases block yyy
// R20: 9666 sets, 9555 clears warning suppression
// R21: read-only flag blocks writes and erases
// R22: no-copy parameters left out of card writes
// R23: one operation at a time, others ignored
module pcc_copy_ctrl
    import pcc_pkg::*;
#(
    parameter int FLASH_CYC = PCC_FLASH_CYC // led half period, cycles
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_up_evt, // one pulse after power-up
    input wire logic drive_reset, // one pulse per drive reset
    input wire logic menu0_chg, // a menu 0 parameter changed
    input wire pcc_card_s card, // card header, level
    input wire logic [1:0] drive_mode, // present operating mode
    output logic op_valid, // card operation request
    input wire logic op_ready, // engine takes the request
    output pcc_op_s op, // operation description
    input wire logic op_done, // pulse, operation finished
    input wire logic op_ok, // finished without card fault
    input wire logic op_match, // compare result
    output logic eeprom_save, // pulse, store to internal eeprom
    output logic [PCC_LEDS-1:0] unit_leds,
    output logic tripped // any trip flag standing
);
    // ============================================================
    // state
    pcc_st_e st_ff, nxt_st; // operation sequencer
    pcc_op_s op_ff; // operation in progress
    logic [PCC_CMD_W-1:0] cmd_ff; // command entry
    pcc_sel_e sel_ff; // copy mode selector
    logic [PCC_TRIP_N-1:0] trip_ff; // sticky trips
    logic sup_ff; // warning suppression flag
    logic ro_ff; // card read-only flag
    logic clr_sel_ff; // selector to idle at success
    logic flash_ff; // leds flash for this operation
    logic save_ff; // eeprom save pulse
    logic [31:0] prdata_ff; // read data captured in setup
    // ============================================================
    // apb decode: zero wait states, error on unmapped address
    logic acc, wr, setup_rd, hit_cmd, hit_sel, hit_stat, hit_tclr;
    logic mapped, busy;
    logic [31:0] stat_w, rd_mux;
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign hit_cmd = paddr == PCC_OFF_CMD;
    assign hit_sel = paddr == PCC_OFF_SEL;
    assign hit_stat = paddr == PCC_OFF_STAT;
    assign hit_tclr = paddr == PCC_OFF_TCLR;
    assign mapped = hit_cmd | hit_sel | hit_stat | hit_tclr;
    assign busy = st_ff != PCC_ST_IDLE;
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = prdata_ff;
    // status word assembly
    always_comb begin
        stat_w = 32'h0;
        stat_w[PCC_TRIP_N-1:0] = trip_ff;
        stat_w[PCC_B_BUSY] = busy;
        stat_w[PCC_B_SUP] = sup_ff;
        stat_w[PCC_B_RO] = ro_ff;
    end
    assign rd_mux = hit_cmd ? 32'(cmd_ff) :
                    hit_sel ? 32'(sel_ff) :
                    hit_stat ? stat_w : 32'h0;
    // commands written while busy are dropped
    logic cmd_wr, sel_wr, sel_legal;
    assign cmd_wr = wr & hit_cmd & ~busy; // see R23
    assign sel_legal = pwdata[2:0] <= PCC_SEL_BOOT;
    assign sel_wr = wr & hit_sel & sel_legal;
    // ============================================================
    // command decode
    pcc_kind_e dk;
    logic [9:0] dblk;
    pcc_cmd_decode u_dec (
        .code(cmd_ff),
        .kind(dk),
        .block(dblk)
    );
    // ============================================================
    // start decision, only taken in idle so one op runs at a time
    pcc_op_s nop; // op about to be issued
    logic go, csel, fl, save_now, cmd_clr;
    logic sup_set, sup_clr, ro_set, ro_clr;
    logic [PCC_TRIP_N-1:0] tset; // trips raised by the decision
    logic mode_bad, idle, wr_like;
    assign idle = st_ff == PCC_ST_IDLE; // see R23
    assign mode_bad = card.mode != drive_mode;
    always_comb begin
        nop = '0;
        go = 1'b0;
        csel = 1'b0;
        fl = 1'b0;
        save_now = 1'b0;
        sup_set = 1'b0;
        sup_clr = 1'b0;
        ro_set = 1'b0;
        ro_clr = 1'b0;
        tset = '0;
        // writes always overwrite an existing block
        nop.excl_nocopy = 1'b1; // see R22 R2
        nop.excl_sel = sel_ff == PCC_SEL_BACKUP; // see R13 R16
        nop.skip_ra = card.volt_diff; // see R6 R7
        nop.keep_default = card.slot_diff; // see R4
        nop.block = PCC_BLOCK1;
        if (!idle) begin
            go = 1'b0;
        end else if (power_up_evt) begin
            if (sel_ff == PCC_SEL_BACKUP) begin
                go = 1'b1; // see R12
                fl = 1'b1;
            end else if (sel_ff == PCC_SEL_BOOT && card.present &&
                         card.block1_ok && card.sel_boot) begin
                nop.op = PCC_OP_LOAD; // see R14
                go = 1'b1;
                fl = 1'b1;
            end
        end else if (drive_reset && cmd_ff != 14'h0000) begin
            case (dk)
                PCC_K_SAVE: begin
                    save_now = 1'b1;
                    go = sel_ff == PCC_SEL_BACKUP; // see R10
                end
                PCC_K_BOOT: begin
                    nop.bootable = 1'b1; // see R17
                    go = 1'b1;
                end
                PCC_K_WRITE: begin
                    nop.block = dblk;
                    go = 1'b1;
                end
                PCC_K_LOAD: begin
                    nop.op = PCC_OP_LOAD; // see R3
                    nop.block = dblk;
                    go = 1'b1;
                end
                PCC_K_ERASE: begin
                    nop.op = PCC_OP_ERASE; // see R19
                    nop.block = dblk;
                    go = 1'b1;
                end
                PCC_K_CMP: begin
                    nop.op = PCC_OP_CMP; // see R18
                    nop.block = dblk;
                    go = ~ro_ff; // see R21
                end
                PCC_K_SUP_SET: sup_set = ~ro_ff; // see R20
                PCC_K_SUP_CLR: sup_clr = ~ro_ff; // see R20
                PCC_K_RO_SET: ro_set = 1'b1; // see R21
                PCC_K_RO_CLR: ro_clr = 1'b1; // see R21
                default: go = 1'b0;
            endcase
        end else if (drive_reset) begin
            case (sel_ff)
                PCC_SEL_TO: begin
                    go = 1'b1; // see R1
                    csel = 1'b1;
                end
                PCC_SEL_FROM: begin
                    nop.op = PCC_OP_LOAD; // see R8
                    go = 1'b1;
                    csel = 1'b1;
                end
                PCC_SEL_BACKUP: go = 1'b1; // see R9
                default: go = 1'b0;
            endcase
        end else if (menu0_chg && sel_ff == PCC_SEL_BACKUP &&
                     card.present) begin
            nop.single = 1'b1; // see R9
            go = 1'b1;
        end
        // a mode mismatch stops any load before it starts
        if (go && nop.op == PCC_OP_LOAD && mode_bad) begin
            go = 1'b0; // see R15
            tset[PCC_T_MODE] = 1'b1;
        end
        // write protection turns writes and erases into a trip
        if (go && wr_like && ro_ff) begin
            go = 1'b0; // see R21
            tset[PCC_T_PROT] = 1'b1;
        end
    end
    assign wr_like = nop.op == PCC_OP_WRITE || nop.op == PCC_OP_ERASE;
    // entry cleared at once when nothing runs, else at completion
    assign cmd_clr = idle & drive_reset & ~power_up_evt & ~go &
                     (cmd_ff != 14'h0000);
    // ============================================================
    // completion handling
    logic fin, fin_ok, cmp_bad, ld_ok;
    logic [PCC_TRIP_N-1:0] tdone; // trips raised at completion
    assign fin = (st_ff == PCC_ST_WAIT) & op_done;
    assign fin_ok = fin & op_ok;
    assign ld_ok = fin_ok & (op_ff.op == PCC_OP_LOAD);
    assign cmp_bad = fin_ok & (op_ff.op == PCC_OP_CMP) & ~op_match;
    always_comb begin
        tdone = '0;
        tdone[PCC_T_CARD] = fin & ~op_ok;
        tdone[PCC_T_CMP] = cmp_bad; // see R18
        // warnings come after the data is in place
        tdone[PCC_T_MODULE] = ld_ok & (|op_ff.keep_default) & ~sup_ff;
        tdone[PCC_T_RATING] = ld_ok & (card.volt_diff | card.curr_diff)
                              & ~sup_ff; // see R5 R20
    end
    // ============================================================
    // sequencer: request held until the engine takes it
    always_comb begin
        case (st_ff)
            PCC_ST_IDLE: nxt_st = go ? PCC_ST_ISSUE : PCC_ST_IDLE;
            PCC_ST_ISSUE: nxt_st = op_ready ? PCC_ST_WAIT : PCC_ST_ISSUE;
            PCC_ST_WAIT: nxt_st = op_done ? PCC_ST_IDLE : PCC_ST_WAIT;
            default: nxt_st = PCC_ST_IDLE;
        endcase
    end
    assign op_valid = st_ff == PCC_ST_ISSUE;
    assign op = op_ff;
    assign tripped = |trip_ff;
    assign eeprom_save = save_ff;
    // ============================================================
    // sequencer and operation registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= PCC_ST_IDLE;
            op_ff <= '0;
            clr_sel_ff <= 1'b0;
            flash_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            if (idle && go) begin
                op_ff <= nop;
                clr_sel_ff <= csel;
                flash_ff <= fl;
            end
        end
    end
    // ============================================================
    // command entry: apb write, cleared when consumed or done, kept after a compare mismatch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff <= 14'h0000;
        end else if (cmd_wr) begin
            cmd_ff <= pwdata[PCC_CMD_W-1:0];
        end else if (cmd_clr || (fin && !cmp_bad)) begin
            cmd_ff <= 14'h0000; // see R18
        end
    end
    // ============================================================
    // selector: software write, removal, success of one-shot modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_ff <= PCC_SEL_IDLE;
        end else if (sel_wr) begin
            sel_ff <= pcc_sel_e'(pwdata[2:0]);
        end else if (sel_ff == PCC_SEL_BACKUP && !card.present) begin
            sel_ff <= PCC_SEL_IDLE; // see R11
        end else if (fin_ok && clr_sel_ff) begin
            sel_ff <= PCC_SEL_IDLE; // see R1 R8
        end
    end
    // ============================================================
    // flags, trips (set beats clear) and eeprom pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_ff <= 1'b0;
            ro_ff <= 1'b0;
            trip_ff <= '0;
            save_ff <= 1'b0;
        end else begin
            sup_ff <= sup_set | (sup_ff & ~sup_clr);
            ro_ff <= ro_set | (ro_ff & ~ro_clr);
            trip_ff <= tset | tdone |
                       (trip_ff & ~((wr & hit_tclr) ?
                                    pwdata[PCC_TRIP_N-1:0] : '0));
            // selector kept across power loss without card copy
            save_ff <= save_now | ld_ok | sel_wr; // see R3 R8 R13
        end
    end
    // read data is captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
        end else if (setup_rd) begin
            prdata_ff <= rd_mux;
        end
    end
    // ============================================================
    // unit leds
    pcc_led_flash #(
        .HALF(FLASH_CYC)
    ) u_led (
        .pclk(pclk),
        .presetn(presetn),
        .active(flash_ff & busy),
        .leds(unit_leds)
    );
    // ============================================================
    // assertions
    property p_busy_ignore;
        @(posedge pclk) disable iff (!presetn)
        (wr && hit_cmd && busy && !fin) |=> $stable(cmd_ff);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) // see R23
        else $error("command entry changed while busy");
    property p_prot;
        @(posedge pclk) disable iff (!presetn)
        (idle && !power_up_evt && drive_reset && ro_ff &&
         dk == PCC_K_ERASE) |=> trip_ff[PCC_T_PROT] && !op_valid;
    endproperty
    a_prot: assert property (p_prot) // see R21
        else $error("erase under read-only did not trip");
    property p_mode;
        @(posedge pclk) disable iff (!presetn)
        (idle && !power_up_evt && drive_reset && cmd_ff == 14'h0000 &&
         sel_ff == PCC_SEL_FROM && mode_bad)
        |=> trip_ff[PCC_T_MODE] && !op_valid ##1 !op_valid;
    endproperty
    a_mode: assert property (p_mode) // see R15
        else $error("mode mismatch load not stopped");
    property p_load_save;
        @(posedge pclk) disable iff (!presetn)
        ld_ok |=> eeprom_save;
    endproperty
    a_load_save: assert property (p_load_save) // see R3
        else $error("load end without eeprom save");
    property p_cmp_bad;
        @(posedge pclk) disable iff (!presetn)
        cmp_bad |=> trip_ff[PCC_T_CMP] && cmd_ff != 14'h0000;
    endproperty
    a_cmp_bad: assert property (p_cmp_bad) // see R18
        else $error("compare mismatch without trip");
    property p_cmp_ok;
        @(posedge pclk) disable iff (!presetn)
        (fin_ok && op_ff.op == PCC_OP_CMP && op_match && !cmd_wr)
        |=> cmd_ff == 14'h0000 && !trip_ff[PCC_T_CMP] ||
            $past(trip_ff[PCC_T_CMP]);
    endproperty
    a_cmp_ok: assert property (p_cmp_ok) // see R18
        else $error("compare match did not clear entry");
    property p_removal;
        @(posedge pclk) disable iff (!presetn)
        (sel_ff == PCC_SEL_BACKUP && !card.present && !sel_wr)
        |=> sel_ff == PCC_SEL_IDLE;
    endproperty
    a_removal: assert property (p_removal) // see R11
        else $error("selector not idled on card removal");
    property p_to_card;
        @(posedge pclk) disable iff (!presetn)
        (idle && !power_up_evt && drive_reset && cmd_ff == 14'h0000 &&
         sel_ff == PCC_SEL_TO && !ro_ff)
        |=> op_valid && op.op == PCC_OP_WRITE && op.block == PCC_BLOCK1;
    endproperty
    a_to_card: assert property (p_to_card) // see R1
        else $error("copy_to_card reset did not write block 1");
    property p_suppress;
        @(posedge pclk) disable iff (!presetn)
        (ld_ok && sup_ff && !trip_ff[PCC_T_MODULE])
        |=> !trip_ff[PCC_T_MODULE];
    endproperty
    a_suppress: assert property (p_suppress) // see R20
        else $error("module trip despite suppression");
    c_load: cover property (@(posedge pclk) disable iff (!presetn)
        ld_ok ##1 eeprom_save);
    c_cmp_bad: cover property (@(posedge pclk) disable iff (!presetn)
        cmp_bad);
    c_boot: cover property (@(posedge pclk) disable iff (!presetn)
        power_up_evt && sel_ff == PCC_SEL_BOOT && go);
endmodule
`default_nettype wire

// ===== verilog/pcc_led_flash.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// blinks the unit leds while a power-up card transfer runs
module pcc_led_flash
    import pcc_pkg::*;
#(
    parameter int HALF = PCC_FLASH_CYC // half period in cycles
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic active,
    output logic [PCC_LEDS-1:0] leds
);
    logic [31:0] cnt_ff; // half period counter
    logic on_ff; // current led phase
    // leds go dark as soon as the transfer ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 32'h0;
            on_ff <= 1'b0;
        end else if (!active) begin
            cnt_ff <= 32'h0;
            on_ff <= 1'b0;
        end else if (cnt_ff >= 32'(HALF - 1)) begin
            cnt_ff <= 32'h0;
            on_ff <= !on_ff;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
        end
    end
    assign leds = {PCC_LEDS{on_ff}};
endmodule
`default_nettype wire
